/* rtl/io_line_params.svh */
`ifndef IO_LINE_PARAMS_SVH
`define IO_LINE_PARAMS_SVH
`define CLOCK_MHZ 25
`define CYCLES_PER_US (`CLOCK_MHZ)
`define DEBOUNCE_MAX_US 1000000
`define FLOOR_MAX_US 100
`define IN_LINES 2
`define OUT_LINES 4
`define DEBOUNCE_W 20
`define FLOOR_W 7
`define DEBOUNCE_RESET 20'h00000
`define FLOOR_RESET 7'h00
`endif

/* rtl/io_line_pkg.sv */
package io_line_pkg;
  typedef logic [19:0] debounce_us_t;
  typedef logic [6:0] floor_us_t;
  typedef logic [2:0] line_sel_t;
  typedef enum logic [2:0]
  {
    SEL_IN1 = 3'h0,
    SEL_IN2 = 3'h1,
    SEL_OUT1 = 3'h2,
    SEL_OUT2 = 3'h3,
    SEL_OUT3 = 3'h4,
    SEL_OUT4 = 3'h5
  } line_choice_e;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h1,
    ST_HOLD = 2'h2
  } stretch_state_e;
endpackage : io_line_pkg

/* rtl/us_tick_if.sv */
`timescale 1ns/1ns
// tick shared between the divider and the line conditioning logic
interface us_tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface : us_tick_if

/* rtl/us_tick_gen.sv */
`timescale 1ns/1ns
`include "io_line_params.svh"
module us_tick_gen
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // tick out
  us_tick_if.source tick_if
);
  localparam logic [4:0] LAST = 5'(`CYCLES_PER_US - 1);
  logic [4:0] count;
  logic [4:0] next_count;
  logic tick;
  logic next_tick;

  always_comb
  begin
    next_tick = (count == LAST);
    next_count = next_tick ? 5'h00 : count + 5'h01;
  end

  // register divider state
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count <= 5'h00;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign tick_if.tick = tick;

  a_tick_period: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    tick |=> !tick [*8])
    else $error("tick repeats too soon");
endmodule : us_tick_gen

/* rtl/io_line_condition.sv */
`timescale 1ns/1ns
`include "io_line_params.svh"
module io_line_condition
  import io_line_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // configuration access
  input wire io_line_pkg::line_sel_t io_line_choice_i,
  input wire logic cfg_write_i,
  input wire io_line_pkg::debounce_us_t input_glitch_filter_time_us_i,
  input wire io_line_pkg::floor_us_t output_pulse_floor_us_i,
  output io_line_pkg::debounce_us_t input_glitch_filter_time_us_o,
  output io_line_pkg::floor_us_t output_pulse_floor_us_o,
  // input pins and filtered levels
  input wire logic [1:0] in_pin_i,
  output logic [1:0] in_level_o,
  // internal output pulses and output pins
  input wire logic [3:0] out_pulse_i,
  output logic [3:0] out_pin_o
);
  import io_line_pkg::*;

  us_tick_if tick_bus ();
  us_tick_gen tick_gen
  (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .tick_if(tick_bus.source)
  );

  debounce_us_t deb_time [`IN_LINES];
  floor_us_t floor_time [`OUT_LINES];
  debounce_us_t next_deb_time [`IN_LINES];
  floor_us_t next_floor_time [`OUT_LINES];
  debounce_us_t rd_deb;
  floor_us_t rd_floor;
  debounce_us_t next_rd_deb;
  floor_us_t next_rd_floor;

  // limit a written value to its range
  function automatic debounce_us_t clamp_deb(input debounce_us_t v);
    clamp_deb = (v > 20'(`DEBOUNCE_MAX_US)) ? 20'(`DEBOUNCE_MAX_US) : v;
  endfunction : clamp_deb

  function automatic floor_us_t clamp_floor(input floor_us_t v);
    clamp_floor = (v > 7'(`FLOOR_MAX_US)) ? 7'(`FLOOR_MAX_US) : v;
  endfunction : clamp_floor

  // per line settings via the line choice
  always_comb
  begin
    next_deb_time = deb_time;
    next_floor_time = floor_time;
    next_rd_deb = 20'h00000;
    next_rd_floor = 7'h00;
    case (io_line_choice_i)
      SEL_IN1, SEL_IN2:
      begin
        if (cfg_write_i)
          next_deb_time[io_line_choice_i[0]] = clamp_deb(input_glitch_filter_time_us_i);
        next_rd_deb = deb_time[io_line_choice_i[0]];
      end
      SEL_OUT1, SEL_OUT2, SEL_OUT3, SEL_OUT4:
      begin
        if (cfg_write_i)
          next_floor_time[2'(io_line_choice_i - 3'h2)] = clamp_floor(output_pulse_floor_us_i);
        next_rd_floor = floor_time[2'(io_line_choice_i - 3'h2)];
      end
      default:
      begin
        next_rd_deb = 20'h00000;
      end
    endcase
  end

  // register configuration
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < `IN_LINES; i++)
        deb_time[i] <= `DEBOUNCE_RESET;
      for (int i = 0; i < `OUT_LINES; i++)
        floor_time[i] <= `FLOOR_RESET;
      rd_deb <= 20'h00000;
      rd_floor <= 7'h00;
    end
    else
    begin
      deb_time <= next_deb_time;
      floor_time <= next_floor_time;
      rd_deb <= next_rd_deb;
      rd_floor <= next_rd_floor;
    end
  end

  assign input_glitch_filter_time_us_o = rd_deb;
  assign output_pulse_floor_us_o = rd_floor;

  // input synchroniser; stage one feeds stage two only
  logic [1:0] in_meta;
  logic [1:0] in_sync;
  logic [1:0] in_prev;
  logic [1:0] level;
  debounce_us_t stable_us [`IN_LINES];
  logic [1:0] next_level;
  debounce_us_t next_stable_us [`IN_LINES];

  // accept after stable time, restart on change
  // the first tick after a restart may come at once, so one extra tick is counted:
  // the level is then stable at least the setting and at most one us longer
  always_comb
  begin
    next_level = level;
    next_stable_us = stable_us;
    for (int i = 0; i < `IN_LINES; i++)
    begin
      if (in_sync[i] != in_prev[i])
        next_stable_us[i] = 20'h00000;
      else if (in_sync[i] != level[i])
      begin
        if (deb_time[i] == 20'h00000 || stable_us[i] > deb_time[i])
          next_level[i] = in_sync[i];
        else if (tick_bus.tick)
          next_stable_us[i] = stable_us[i] + 20'h00001;
      end
      else
        next_stable_us[i] = 20'h00000;
    end
  end

  // register input filter
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      in_meta <= 2'h0;
      in_sync <= 2'h0;
      in_prev <= 2'h0;
      level <= 2'h0;
      for (int i = 0; i < `IN_LINES; i++)
        stable_us[i] <= 20'h00000;
    end
    else
    begin
      in_meta <= in_pin_i;
      in_sync <= in_meta;
      in_prev <= in_sync;
      level <= next_level;
      stable_us <= next_stable_us;
    end
  end

  assign in_level_o = level;

  // output stretchers
  stretch_state_e st [`OUT_LINES];
  stretch_state_e next_st [`OUT_LINES];
  floor_us_t width_us [`OUT_LINES];
  floor_us_t next_width_us [`OUT_LINES];
  // per line microsecond phase, restarted by each pulse that starts from idle so the floor is exact
  localparam logic [4:0] PH_LAST = 5'(`CYCLES_PER_US - 1);
  logic [4:0] ph [`OUT_LINES];
  logic [4:0] next_ph [`OUT_LINES];
  logic [3:0] pin;
  logic [3:0] next_pin;

  // hold high until floor reached and source has dropped
  // a shared tick would let the first microsecond come short, hence the own phase
  always_comb
  begin
    next_st = st;
    next_width_us = width_us;
    next_ph = ph;
    next_pin = pin;
    for (int i = 0; i < `OUT_LINES; i++)
    begin
      case (st[i])
        ST_IDLE:
        begin
          next_pin[i] = out_pulse_i[i];
          next_width_us[i] = 7'h00;
          next_ph[i] = 5'h00;
          if (out_pulse_i[i])
            next_st[i] = ST_HOLD;
        end
        ST_HOLD:
        begin
          next_ph[i] = (ph[i] == PH_LAST) ? 5'h00 : ph[i] + 5'h01;
          if (ph[i] == PH_LAST && width_us[i] < floor_time[i])
            next_width_us[i] = width_us[i] + 7'h01;
          // drop on the edge that completes the floor, not one cycle later
          if (!out_pulse_i[i] && next_width_us[i] >= floor_time[i])
          begin
            next_pin[i] = 1'b0;
            next_st[i] = ST_IDLE;
          end
          else
            next_pin[i] = 1'b1;
        end
        default:
        begin
          next_st[i] = ST_IDLE;
          next_pin[i] = 1'b0;
        end
      endcase
    end
  end

  // register stretchers
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin <= 4'h0;
      for (int i = 0; i < `OUT_LINES; i++)
      begin
        st[i] <= ST_IDLE;
        width_us[i] <= 7'h00;
        ph[i] <= 5'h00;
      end
    end
    else
    begin
      pin <= next_pin;
      st <= next_st;
      width_us <= next_width_us;
      ph <= next_ph;
    end
  end

  assign out_pin_o = pin;

  a_out_follows: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(out_pulse_i[0]) && st[0] == ST_IDLE |=> pin[0])
    else $error("pulse not passed");
  a_out_held: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    pin[0] && width_us[0] + 7'h01 < floor_time[0] |=> pin[0])
    else $error("pulse cut short");
  a_stretch_end: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    pin[0] && !out_pulse_i[0] && width_us[0] >= floor_time[0] |=> !pin[0])
    else $error("pulse held too long");
  a_floor_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    pin[0] && !out_pulse_i[0] && floor_time[0] == 7'h00 |=> !pin[0])
    else $error("zero floor stretched");
  a_level_stable: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    level[0] != $past(level[0]) |->
      $past(stable_us[0]) > $past(deb_time[0]) || $past(deb_time[0]) == 20'h00000)
    else $error("early accept");
  a_raw_restart: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    in_sync[0] != in_prev[0] |=> $stable(level[0]) && stable_us[0] == 20'h00000)
    else $error("count not restarted");
endmodule : io_line_condition

/* verification/line_partner.sv */
`timescale 1ns/1ns
// far-side trigger source; pins idle low between pulses
module line_partner
(
  // clock
  input wire logic clock_i,
  // pins toward the device
  output logic [1:0] pin_o
);
  initial pin_o = 2'h0;
  task automatic pulse(input int line, input int cyc);
    @(negedge clock_i);
    pin_o[line] = 1'b1;
    repeat (cyc) @(negedge clock_i);
    pin_o[line] = 1'b0;
  endtask : pulse
endmodule : line_partner

/* verification/tb_io_line_debounce_pulse_stretch.sv */
`timescale 1ns/1ns
module tb_io_line_debounce_pulse_stretch;
  import io_line_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  line_sel_t sel = 3'h0;
  logic wr = 1'b0;
  debounce_us_t dbi = 20'h00000;
  floor_us_t fli = 7'h00;
  debounce_us_t dbo;
  floor_us_t flo;
  logic [1:0] pin;
  logic [1:0] lvl;
  logic [3:0] pls = 4'h0;
  logic [3:0] opin;
  int n_fail = 0;
  int checks = 0;
  int seed = 38709;
  int cfg [6];
  int fl [4] = '{4, 4, 0, 100};
  int wd [4] = '{1, 200, 1, 3};
  int t;
  int d;
  int f;
  int w;
  // free-running 25 MHz clock
  always #20 clock_i = ~clock_i;
  io_line_condition u_io_line_condition
  (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .io_line_choice_i(sel),
    .cfg_write_i(wr),
    .input_glitch_filter_time_us_i(dbi),
    .output_pulse_floor_us_i(fli),
    .input_glitch_filter_time_us_o(dbo),
    .output_pulse_floor_us_o(flo),
    .in_pin_i(pin),
    .in_level_o(lvl),
    .out_pulse_i(pls),
    .out_pin_o(opin)
  );
  line_partner u_line_partner
  (
    .clock_i(clock_i),
    .pin_o(pin)
  );
  // one place for every comparison
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // write one line setting and update the reference copy, clamped
  task automatic put(input int s, input int v);
    int m;
    @(negedge clock_i);
    sel = s[2:0];
    wr = 1'b1;
    dbi = v[19:0];
    fli = v[6:0];
    @(negedge clock_i);
    wr = 1'b0;
    m = s < 2 ? 1000000 : 100;
    v = s < 2 ? v % 1048576 : v % 128;
    cfg[s] = v > m ? m : v;
  endtask : put
  // readback lands one cycle after the selection changes
  task automatic rd(input int s);
    @(negedge clock_i);
    sel = s[2:0];
    @(negedge clock_i);
    if (s < 2)
      check("debounce", dbo, cfg[s]);
    else
    begin
      check("debounce_off", dbo, 0);
      check("floor", flo, cfg[s]);
    end
  endtask : rd
  // hang guard, far beyond the longest pass
  initial
  begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(negedge clock_i);
    rst_b_i = 1'b1;
    check("idle", {lvl, opin, dbo, flo}, 0);
    for (int s = 0; s < 6; s++)
      put(s, $random(seed) & 'hFFFFF);
    for (int s = 0; s < 6; s++)
      rd(s);
    put(1, 'hFFFFF);
    put(5, 'h7F);
    rd(1);
    rd(5);
    // filter and delay, zero setting last
    for (int i = 0; i < 3; i++)
    begin
      d = i == 2 ? 0 : 4 * i + 4;
      put(i % 2, d);
      if (d > 0)
      begin
        u_line_partner.pulse(i % 2, d * 25 - 30);
        repeat (d * 25 + 30) @(negedge clock_i);
        check("glitch", lvl[i % 2], 1'b0);
      end
      t = 0;
      fork
        u_line_partner.pulse(i % 2, d * 75 + 50);
        while (lvl[i % 2] !== 1'b1 && t < d * 25 + 60)
        begin
          @(negedge clock_i);
          t++;
        end
      join
      check("delay", t >= d * 25 && t <= d * 25 + 30, 1'b1);
      repeat (d * 25 + 60) @(negedge clock_i);
    end
    for (int i = 0; i < 4; i++)
    begin
      put(i + 2, fl[i]);
      f = fl[i] * 25;
      w = wd[i];
      t = 0;
      @(negedge clock_i);
      fork
        begin
          pls[i] = 1'b1;
          repeat (w) @(negedge clock_i);
          pls[i] = 1'b0;
        end
        repeat (3000)
        begin
          @(negedge clock_i);
          t += opin[i] === 1'b1;
        end
      join
      check("width", t >= (w > f ? w : f) && t <= (w > f ? w : f + 26), 1'b1);
    end
    wrap_up();
  end
endmodule : tb_io_line_debounce_pulse_stretch
